// file: core/scl_defs.svh
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define SCL_CLK_PERIOD_NS 100
`define SCL_MCLK_PERIOD_NS 1000
`define SCL_MCLK_HALF_CYC ((`SCL_MCLK_PERIOD_NS / 2 + `SCL_CLK_PERIOD_NS - 1) / `SCL_CLK_PERIOD_NS)
`define SCL_GAP_CYC (2 * `SCL_MCLK_HALF_CYC)
`define SCL_WR_TIMEOUT_US 10000
`define SCL_WR_TIMEOUT_CYC (`SCL_WR_TIMEOUT_US * 1000 / `SCL_CLK_PERIOD_NS)

// ****************************************
// Memory organisation and commands
// ****************************************
`define SCL_DATA_W 16
`define SCL_ADDR_W_DEF 6
`define SCL_WORDS_DEF 64
`define SCL_OP_READ 2'h2
`define SCL_OP_WRITE 2'h1
`define SCL_OP_EWEN 2'h0
`define SCL_EWEN_TAG 2'h3

// ****************************************
// Stored configuration layout
// ****************************************
`define SCL_MODE_A_LSB 0
`define SCL_MODE_B_LSB 2
`define SCL_CHK_SEED 16'hA55A

`endif

// file: core/scl_pkg.sv
package scl_pkg;

	// Channel operating modes
	typedef enum logic [1:0] {
		SCL_MODE_UART = 2'h0,
		SCL_MODE_FIFO = 2'h1,
		SCL_MODE_OPTO = 2'h2
	} scl_mode_t;

	// Applied per-channel configuration
	typedef struct packed {
		scl_mode_t mode_b;
		scl_mode_t mode_a;
	} scl_chan_cfg_t;

	// Write request from the USB side
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} scl_wr_req_t;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_GAP = 4'h2,
		ST_FRAME = 4'h4,
		ST_POLL = 4'h8
	} scl_state_t;

	// Kind of memory job in progress
	typedef enum logic [3:0] {
		JOB_LOAD = 4'h1,
		JOB_EWEN = 4'h2,
		JOB_WRITE = 4'h4,
		JOB_POLL = 4'h8
	} scl_job_t;

	// Unknown field codes fall back to the serial mode
	function automatic scl_mode_t scl_mode_decode(input logic [1:0] f);
		scl_mode_t m;
		m = SCL_MODE_UART;
		if (f == 2'h1) begin
			m = SCL_MODE_FIFO;
		end else if (f == 2'h2) begin
			m = SCL_MODE_OPTO;
		end
		return m;
	endfunction

endpackage

// file: core/scl_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Three-stage input synchroniser
// ****************************************
module scl_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous input and clean level
	input wire logic d_i,
	output logic q_o
);
	logic s1;
	logic s2;
	logic s3;

	// Only the second stage reads the first; output moves once stages two and three agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q_o <= s3;
			end
		end
	end
endmodule

`default_nettype wire

// file: core/scl_config_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.svh"

// ****************************************
// Function
// - Scan the configuration memory after power-on and after every USB bus reset.
// - Apply stored settings when memory present and valid, else built-in defaults.
// - Built-in defaults put both channels in asynchronous serial mode.
// - Data line high during acknowledge means bad command or no memory.
// - During reset the select, clock and data pins are high impedance.
// - After reset release load configuration first, only then allow enumeration.
// - Select and clock on own outputs; commands and data share one data pin.
// - Parallel or opto modes only when stored configuration selects them.
// - Reference clock from a CMOS oscillator; oscillator output left unconnected.
// - New memory contents can be written on request from the USB side.
// - In serial mode each channel drives transmit and samples receive.
// - Interface pins float, weakly pulled high, while the device is in reset.
// ****************************************

module scl_config_loader #(
	parameter int ADDR_W = `SCL_ADDR_W_DEF,
	parameter int WORDS = `SCL_WORDS_DEF,
	parameter int WR_TIMEOUT_CYC = `SCL_WR_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// USB side control
	input wire logic usb_bus_reset_i,
	input wire logic wr_valid_i,
	input wire scl_pkg::scl_wr_req_t wr_req_i,
	output logic wr_ready_o,
	output logic wr_done_o,
	output logic wr_err_o,
	// Load status and applied configuration
	output logic load_done_o,
	output logic mem_present_o,
	output logic cfg_valid_o,
	output var scl_pkg::scl_chan_cfg_t chan_cfg_o,
	// Configuration memory pins
	output logic cfg_mem_select_o,
	output logic cfg_mem_select_oe_n_o,
	output logic cfg_mem_clock_o,
	output logic cfg_mem_clock_oe_n_o,
	input wire logic cfg_mem_data_io_i,
	output logic cfg_mem_data_io_o,
	output logic cfg_mem_data_io_oe_n_o,
	// Channel serial pins
	input wire logic [1:0] chan_txd_i,
	output logic [1:0] chan_txd_o,
	output logic [1:0] chan_txd_oe_n_o,
	input wire logic [1:0] chan_rxd_i,
	output logic [1:0] chan_rxd_o,
	// Oscillator
	output logic osc_output_o
);
	// ****************************************
	// Constants and state
	// ****************************************
	localparam int HALF = `SCL_MCLK_HALF_CYC;
	localparam int GAP = `SCL_GAP_CYC;
	localparam int DW = `SCL_DATA_W;
	localparam int CMD_W = 3 + ADDR_W;
	localparam int TX_W = CMD_W + DW;
	localparam int IN_W = DW + 1;
	localparam int IDX_W = $clog2(WORDS);
	localparam int POLL_W = $clog2(WR_TIMEOUT_CYC + 1);

	scl_pkg::scl_state_t state;
	scl_pkg::scl_job_t job;
	scl_pkg::scl_wr_req_t wr_lat;
	logic [4:0] tmr;
	logic [5:0] bit_cnt;
	logic [5:0] out_len;
	logic [5:0] tot_len;
	logic [TX_W-1:0] tx_sr;
	logic [IN_W-1:0] rx_sr;
	logic [IDX_W-1:0] word_idx;
	logic [DW-1:0] chk;
	logic [DW-1:0] mode_word;
	logic [POLL_W-1:0] poll_cnt;
	logic load_pend;
	logic data_q;

	// ****************************************
	// Input synchronisers
	// ****************************************
	scl_sync3 #(.RST_VAL(1'b1)) u_data_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(cfg_mem_data_io_i),
		.q_o(data_q)
	);

	// Receive lines idle high, so the synchronisers start there
	for (genvar ch = 0; ch < 2; ch++) begin : g_rx
		scl_sync3 #(.RST_VAL(1'b1)) u_rx_sync (
			.clk_i(ref_clk_i),
			.rst_n_i(rst_n_i),
			.d_i(chan_rxd_i[ch]),
			.q_o(chan_rxd_o[ch])
		);
	end

	// ****************************************
	// Frame decode
	// ****************************************
	// Half-bit timer sets the serial clock rate; the memory must keep up with it
	wire half_end = tmr == 5'(HALF - 1);
	wire gap_end = tmr == 5'(GAP - 1);
	wire [ADDR_W-1:0] rd_addr = ADDR_W'(word_idx);
	wire [ADDR_W-1:0] ewen_addr = {`SCL_EWEN_TAG, {(ADDR_W - 2){1'b0}}};
	wire [TX_W-1:0] rd_frame = {1'b1, `SCL_OP_READ, rd_addr, {DW{1'b0}}};
	wire [TX_W-1:0] ewen_frame = {1'b1, `SCL_OP_EWEN, ewen_addr, {DW{1'b0}}};
	wire [TX_W-1:0] wr_frame = {1'b1, `SCL_OP_WRITE, wr_lat.addr[ADDR_W-1:0], wr_lat.data};
	wire [TX_W-1:0] nf_tx = (job == scl_pkg::JOB_LOAD) ? rd_frame :
		(job == scl_pkg::JOB_EWEN) ? ewen_frame : wr_frame;
	wire [5:0] nf_out = (job == scl_pkg::JOB_WRITE) ? 6'(TX_W) : 6'(CMD_W);
	wire [5:0] nf_tot = (job == scl_pkg::JOB_LOAD) ? 6'(CMD_W + IN_W) : nf_out;
	wire in_bit = bit_cnt >= out_len;
	wire low_end = (state == scl_pkg::ST_FRAME) && !cfg_mem_clock_o && half_end;
	wire high_end = (state == scl_pkg::ST_FRAME) && cfg_mem_clock_o && half_end;
	wire frame_last = high_end && (bit_cnt == tot_len - 6'h01);
	wire next_drive = (bit_cnt + 6'h01) < out_len;

	// First input bit of a read is the acknowledge slot
	wire ack_smp = low_end && (job == scl_pkg::JOB_LOAD) && (bit_cnt == out_len);

	// ****************************************
	// Load result
	// ****************************************
	// Only whole sixteen-bit words are taken from the memory
	wire [DW-1:0] rd_word = rx_sr[DW-1:0];
	wire [DW-1:0] next_chk = chk ^ rd_word;
	wire [DW-1:0] cfg_word = (word_idx == '0) ? rd_word : mode_word;
	wire last_word = word_idx == IDX_W'(WORDS - 1);
	wire load_end = !mem_present_o || last_word;
	wire valid_now = mem_present_o && (next_chk == `SCL_CHK_SEED);
	wire usb_quiet = !load_pend && !usb_bus_reset_i;
	wire [1:0] fld_a = cfg_word[`SCL_MODE_A_LSB +: 2];
	wire [1:0] fld_b = cfg_word[`SCL_MODE_B_LSB +: 2];
	wire scl_pkg::scl_chan_cfg_t cfg_stored = '{
		mode_b: scl_pkg::scl_mode_decode(fld_b),
		mode_a: scl_pkg::scl_mode_decode(fld_a)
	};
	wire scl_pkg::scl_chan_cfg_t cfg_default = '{
		mode_b: scl_pkg::SCL_MODE_UART,
		mode_a: scl_pkg::SCL_MODE_UART
	};

	// Write completion: early samples still see the pulled-up idle line
	wire wr_take = wr_valid_i && wr_ready_o;
	wire poll_ready = data_q && (poll_cnt >= POLL_W'(HALF));
	wire poll_tmo = poll_cnt == POLL_W'(WR_TIMEOUT_CYC - 1);

	// Serial drivers run only once loaded and only in serial mode
	wire [1:0] uart_drive = {
		load_done_o && (chan_cfg_o.mode_b == scl_pkg::SCL_MODE_UART),
		load_done_o && (chan_cfg_o.mode_a == scl_pkg::SCL_MODE_UART)
	};

	// ****************************************
	// Sequencer
	// ****************************************
	// Load runs word by word; a missing acknowledge ends it early with defaults
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= scl_pkg::ST_IDLE;
			job <= scl_pkg::JOB_LOAD;
			wr_lat <= '0;
			tmr <= 5'h00;
			bit_cnt <= 6'h00;
			out_len <= 6'h00;
			tot_len <= 6'h00;
			tx_sr <= '0;
			rx_sr <= '0;
			word_idx <= '0;
			chk <= 16'h0000;
			mode_word <= 16'h0000;
			poll_cnt <= '0;
			load_pend <= 1'b1;
			load_done_o <= 1'b0;
			mem_present_o <= 1'b0;
			cfg_valid_o <= 1'b0;
			chan_cfg_o <= '0;
			wr_ready_o <= 1'b0;
			wr_done_o <= 1'b0;
			wr_err_o <= 1'b0;
			cfg_mem_select_o <= 1'b0;
			cfg_mem_clock_o <= 1'b0;
			cfg_mem_data_io_o <= 1'b1;
			cfg_mem_data_io_oe_n_o <= 1'b1;
		end else begin
			wr_done_o <= 1'b0;
			wr_err_o <= 1'b0;
			tmr <= 5'(tmr + 5'h01);
			if (usb_bus_reset_i) begin
				load_pend <= 1'b1;
				load_done_o <= 1'b0;
			end
			unique case (state)
				scl_pkg::ST_IDLE: begin
					tmr <= 5'h00;
					if (load_pend && !usb_bus_reset_i) begin
						load_pend <= 1'b0;
						job <= scl_pkg::JOB_LOAD;
						word_idx <= '0;
						chk <= 16'h0000;
						mem_present_o <= 1'b1;
						load_done_o <= 1'b0;
						wr_ready_o <= 1'b0;
						state <= scl_pkg::ST_GAP;
					end else if (wr_take) begin
						wr_lat <= wr_req_i;
						job <= scl_pkg::JOB_EWEN;
						wr_ready_o <= 1'b0;
						state <= scl_pkg::ST_GAP;
					end else begin
						wr_ready_o <= load_done_o && usb_quiet;
					end
				end
				scl_pkg::ST_GAP: begin
					cfg_mem_select_o <= 1'b0;
					cfg_mem_clock_o <= 1'b0;
					cfg_mem_data_io_oe_n_o <= 1'b1;
					if (gap_end) begin
						tmr <= 5'h00;
						cfg_mem_select_o <= 1'b1;
						if (job == scl_pkg::JOB_POLL) begin
							poll_cnt <= '0;
							state <= scl_pkg::ST_POLL;
						end else begin
							tx_sr <= nf_tx;
							out_len <= nf_out;
							tot_len <= nf_tot;
							bit_cnt <= 6'h00;
							cfg_mem_data_io_o <= nf_tx[TX_W-1];
							cfg_mem_data_io_oe_n_o <= 1'b0;
							state <= scl_pkg::ST_FRAME;
						end
					end
				end
				scl_pkg::ST_FRAME: begin
					if (half_end) begin
						tmr <= 5'h00;
						cfg_mem_clock_o <= !cfg_mem_clock_o;
					end
					if (low_end && in_bit) begin
						rx_sr <= {rx_sr[IN_W-2:0], data_q};
					end
					if (ack_smp && data_q) begin
						mem_present_o <= 1'b0;
					end
					if (frame_last) begin
						cfg_mem_select_o <= 1'b0;
						cfg_mem_data_io_oe_n_o <= 1'b1;
						state <= scl_pkg::ST_GAP;
						unique case (job)
							scl_pkg::JOB_LOAD: begin
								chk <= next_chk;
								if (word_idx == '0) begin
									mode_word <= rd_word;
								end
								if (load_end) begin
									load_done_o <= usb_quiet;
									cfg_valid_o <= valid_now;
									chan_cfg_o <= valid_now ? cfg_stored : cfg_default;
									state <= scl_pkg::ST_IDLE;
								end else begin
									word_idx <= IDX_W'(word_idx + 1'b1);
								end
							end
							scl_pkg::JOB_EWEN: begin
								job <= scl_pkg::JOB_WRITE;
							end
							default: begin
								job <= scl_pkg::JOB_POLL;
							end
						endcase
					end else if (high_end) begin
						bit_cnt <= 6'(bit_cnt + 6'h01);
						tx_sr <= {tx_sr[TX_W-2:0], 1'b0};
						cfg_mem_data_io_o <= tx_sr[TX_W-2];
						cfg_mem_data_io_oe_n_o <= !next_drive;
					end
				end
				scl_pkg::ST_POLL: begin
					poll_cnt <= POLL_W'(poll_cnt + 1'b1);
					if (poll_ready || poll_tmo) begin
						cfg_mem_select_o <= 1'b0;
						wr_done_o <= 1'b1;
						wr_err_o <= !poll_ready;
						state <= scl_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	// Select and clock float only under reset, which lets another controller use the memory then
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_mem_select_oe_n_o <= 1'b1;
			cfg_mem_clock_oe_n_o <= 1'b1;
			chan_txd_o <= 2'h3;
			chan_txd_oe_n_o <= 2'h3;
			osc_output_o <= 1'b0;
		end else begin
			cfg_mem_select_oe_n_o <= 1'b0;
			cfg_mem_clock_oe_n_o <= 1'b0;
			chan_txd_o <= chan_txd_i;
			chan_txd_oe_n_o <= ~uart_drive;
			osc_output_o <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_usb_reload: assert property ($rose(usb_bus_reset_i) |=> !load_done_o)
		else $error("load_done stayed high after USB reset");
	chk_default_cfg: assert property (($rose(load_done_o) && !cfg_valid_o) |-> chan_cfg_o == cfg_default)
		else $error("invalid load did not apply serial defaults");
	chk_ack_abort: assert property ((ack_smp && data_q) |=> !mem_present_o ##165 state == scl_pkg::ST_IDLE)
		else $error("missing acknowledge did not end the load");
	chk_clk_high_time: assert property ($rose(cfg_mem_clock_o) |-> cfg_mem_clock_o[*5] ##1 !cfg_mem_clock_o)
		else $error("serial clock high phase is not five cycles");
	chk_enum_after_load: assert property ((state == scl_pkg::ST_FRAME && job == scl_pkg::JOB_LOAD) |-> !load_done_o)
		else $error("enumeration allowed during load");
	chk_data_in_cmd: assert property (!cfg_mem_data_io_oe_n_o |-> cfg_mem_select_o)
		else $error("data driven outside a command");
	chk_mode_gate: assert property ((chan_cfg_o != cfg_default) |-> cfg_valid_o)
		else $error("non-serial mode without valid stored configuration");
	chk_wr_launch: assert property (wr_take |=> !wr_ready_o ##[1:12] $rose(cfg_mem_select_o))
		else $error("write request did not start a command");
	chk_uart_float: assert property ((!load_done_o && !$past(load_done_o)) |-> chan_txd_oe_n_o == 2'h3)
		else $error("transmit pins driven before configuration");
	chk_data_edge: assert property (($changed(cfg_mem_data_io_o) && !cfg_mem_data_io_oe_n_o) |-> !cfg_mem_clock_o)
		else $error("data changed while serial clock high");
	chk_start_bit: assert property (($rose(cfg_mem_select_o) && !cfg_mem_data_io_oe_n_o) |-> cfg_mem_data_io_o)
		else $error("command did not open with a start bit");
	chk_cs_gap: assert property ($fell(cfg_mem_select_o) |-> !cfg_mem_select_o[*8])
		else $error("select low gap too short");
endmodule

`default_nettype wire

// file: verification/scl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Word-wide three-wire configuration memory
// ****************************************
module scl_mem_model #(
	parameter int ADDR_W = 6
) (
	// Memory pins
	input wire logic cs_i,
	input wire logic mclk_i,
	input wire logic di_i,
	output logic do_o,
	output logic do_en_o
);
	logic [15:0] mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0] rd_log [$];
	logic present = 1'b1;
	int busy_ns = 3000;
	logic busy = 1'b0;
	logic ewen = 1'b0;
	logic wr_pend = 1'b0;
	logic rd = 1'b0;
	logic poll = 1'b0;
	logic rd_bit = 1'b1;
	logic [15:0] out;
	logic [31:0] sh;
	int n;

	// Drives only while selected; once released the board pull-up owns the line
	assign do_en_o = present && cs_i && (poll || rd);
	assign do_o = poll ? !busy : rd_bit;

	// New command: clear the shifter, show ready status until the first clock
	always @(posedge cs_i) begin
		n = 0;
		sh = 32'h0;
		poll = 1'b1;
	end

	// A finished write keeps the array busy for a while after select drops
	always @(negedge cs_i) begin
		rd = 1'b0;
		poll = 1'b0;
		if (wr_pend) begin
			wr_pend = 1'b0;
			busy = 1'b1;
			busy <= #(busy_ns) 1'b0;
		end
	end

	// Bits taken on rising clock, whole 16-bit words only, at any clock rate
	always @(posedge mclk_i) begin
		poll = 1'b0;
		if (cs_i && rd) begin
			rd_bit = out[15];
			out = out << 1;
		end else if (cs_i) begin
			n = n + 1;
			sh = {sh[30:0], di_i};
			if (n == 3 + ADDR_W && sh[ADDR_W+1 -: 2] == 2'h2) begin
				rd = 1'b1;
				rd_bit = 1'b0; // Dummy low bit acknowledges the command
				out = mem[sh[ADDR_W-1:0]];
				rd_log.push_back(sh[ADDR_W-1:0]);
			end
			if (n == 3 + ADDR_W && sh[ADDR_W+1 -: 2] == 2'h0 && sh[ADDR_W-1 -: 2] == 2'h3) begin
				ewen = 1'b1;
			end
			if (n == 19 + ADDR_W && sh[ADDR_W+17 -: 2] == 2'h1 && ewen) begin
				mem[sh[ADDR_W+15 -: ADDR_W]] = sh[15:0];
				wr_pend = 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end

// ****************************************
// Loader bench
// ****************************************
module tb_top;
	logic clk, rst_n, usb_rst, wr_valid, wr_ready, wr_done, wr_err;
	logic load_done, present, cfg_valid, osc;
	logic sel, sel_oe_n, mclk, mclk_oe_n, d_o, d_oe_n, m_do, m_en;
	logic [1:0] txd_i, txd_o, txd_oe_n, rxd_i, rxd_o;
	scl_pkg::scl_wr_req_t wr_req;
	scl_pkg::scl_chan_cfg_t chan_cfg;
	int mismatches = 0;
	int checked = 0;
	int sel_cnt = 0;
	wire logic line = !d_oe_n ? d_o : (m_en ? m_do : 1'b1);

	scl_config_loader #(.ADDR_W(6), .WORDS(4), .WR_TIMEOUT_CYC(200)) u_dut (
		.ref_clk_i(clk), .rst_n_i(rst_n), .usb_bus_reset_i(usb_rst), .wr_valid_i(wr_valid),
		.wr_req_i(wr_req), .wr_ready_o(wr_ready), .wr_done_o(wr_done), .wr_err_o(wr_err),
		.load_done_o(load_done), .mem_present_o(present), .cfg_valid_o(cfg_valid),
		.chan_cfg_o(chan_cfg), .cfg_mem_select_o(sel), .cfg_mem_select_oe_n_o(sel_oe_n),
		.cfg_mem_clock_o(mclk), .cfg_mem_clock_oe_n_o(mclk_oe_n), .cfg_mem_data_io_i(line),
		.cfg_mem_data_io_o(d_o), .cfg_mem_data_io_oe_n_o(d_oe_n), .chan_txd_i(txd_i),
		.chan_txd_o(txd_o), .chan_txd_oe_n_o(txd_oe_n), .chan_rxd_i(rxd_i),
		.chan_rxd_o(rxd_o), .osc_output_o(osc));

	scl_mem_model #(.ADDR_W(6)) u_mem (.cs_i(sel), .mclk_i(mclk), .di_i(line), .do_o(m_do), .do_en_o(m_en));

	// Clock, and a watchdog sized well above all scenarios together
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#(60000 * 100);
		mismatches++;
		end_sim();
	end
	always @(posedge sel) sel_cnt++;

	task automatic end_sim();
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Last word is chosen so that the stored words check out
	task automatic set_mem(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
		u_mem.mem[0] = w0;
		u_mem.mem[1] = w1;
		u_mem.mem[2] = w2;
		u_mem.mem[3] = 16'hA55A ^ w0 ^ w1 ^ w2;
	endtask

	task automatic wait_load();
		int i;
		for (i = 0; i < 4000 && load_done !== 1'b1; i++) @(negedge clk);
		`CHK("load_done", 1'b1, load_done)
	endtask

	// Sharing controller holds reset while it owns the memory pins
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("pin floats", 3'h7, {sel_oe_n, mclk_oe_n, d_oe_n})
		`CHK("chan floats", 2'h3, txd_oe_n)
		`CHK("txd idle", 2'h3, txd_o)
		sel_cnt = 0;
		u_mem.rd_log.delete();
		rst_n = 1'b1;
		repeat (20) @(negedge clk);
		`CHK("early done", 1'b0, load_done)
		`CHK("early ready", 1'b0, wr_ready)
		`CHK("pins driven", 2'h0, {sel_oe_n, mclk_oe_n})
		wait_load();
	endtask

	task automatic usb_reload();
		usb_rst = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("done cleared", 1'b0, load_done)
		usb_rst = 1'b0;
		wait_load();
	endtask

	task automatic t_stored();
		int i;
		set_mem(16'h0009, 16'h1234, 16'h8001);
		do_reset();
		`CHK("present", 1'b1, present)
		`CHK("valid", 1'b1, cfg_valid)
		`CHK("modes", 4'h9, chan_cfg)
		`CHK("serial off", 2'h3, txd_oe_n)
		`CHK("selects", 4, sel_cnt)
		`CHK("reads", 4, u_mem.rd_log.size())
		for (i = 0; i < 4 && i < u_mem.rd_log.size(); i++) begin
			`CHK("read addr", i[5:0], u_mem.rd_log[i])
		end
	endtask

	task automatic t_bad_sum();
		u_mem.mem[1] = 16'h1235;
		usb_reload();
		`CHK("present", 1'b1, present)
		`CHK("valid", 1'b0, cfg_valid)
		`CHK("modes", 4'h0, chan_cfg)
		// Pin enables follow load_done one clock later
		@(negedge clk);
		`CHK("serial on", 2'h0, txd_oe_n)
	endtask

	task automatic t_uart();
		txd_i = 2'h2;
		rxd_i = 2'h1;
		@(negedge clk);
		`CHK("txd", 2'h2, txd_o)
		repeat (5) @(negedge clk);
		`CHK("rxd", 2'h1, rxd_o)
		`CHK("osc out", 1'b0, osc)
	endtask

	task automatic t_absent();
		u_mem.present = 1'b0;
		usb_reload();
		`CHK("absent", 1'b0, present)
		`CHK("valid", 1'b0, cfg_valid)
		`CHK("modes", 4'h0, chan_cfg)
		u_mem.present = 1'b1;
	endtask

	task automatic do_write(input logic [7:0] a, input logic [15:0] d, input logic exp_err);
		int i;
		for (i = 0; i < 3000 && wr_ready !== 1'b1; i++) @(negedge clk);
		wr_req = {a, d};
		wr_valid = 1'b1;
		@(negedge clk);
		wr_valid = 1'b0;
		for (i = 0; i < 3000 && wr_done !== 1'b1; i++) @(negedge clk);
		`CHK("wr_done", 1'b1, wr_done)
		`CHK("wr_err", exp_err, wr_err)
		`CHK("stored", d, u_mem.mem[a[5:0]])
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		usb_rst = 1'b0;
		wr_valid = 1'b0;
		wr_req = '0;
		txd_i = 2'h3;
		rxd_i = 2'h3;
		t_stored();
		t_bad_sum();
		t_uart();
		t_absent();
		// Channel A opto, channel B field code 3 falls back to serial
		set_mem(16'h000E, 16'h0F0F, 16'h00FF);
		do_reset();
		`CHK("modes", 4'h2, chan_cfg)
		@(negedge clk);
		`CHK("serial b only", 2'h1, txd_oe_n)
		do_write(8'h02, 16'hBEEF, 1'b0);
		u_mem.busy_ns = 50000;
		do_write(8'h03, 16'h1234, 1'b1);
		end_sim();
	end
endmodule

`default_nettype wire
